/* File: rtl/fam_flash_core.sv */
// Array, security-register and parameter-space core of a serial NOR
// flash. Assumes a same-clock command front end: one request per
// handshake, one answer pulse per request.
`timescale 1ns/1ns
`default_nettype none
module fam_flash_core #(
    parameter logic [511:0] BASIC_TABLE = {512{1'b1}}
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Requests
    input wire logic req_valid,
    input wire fam_pkg::fam_req_s req,
    output logic req_ready,
    // Answers
    output logic rsp_valid,
    output fam_pkg::fam_rsp_s rsp,
    // Status
    output logic busy,
    output logic [3:0] sreg_lock
);
    localparam int AW = fam_pkg::ARRAY_AW;
    localparam int SW = $clog2(3 * fam_pkg::SREG_BYTES);

    typedef enum logic {FAM_IDLE, FAM_ERASE} fam_state_e;

    // Whole array is an array of bytes; erase walks it a byte a cycle
    logic [7:0] main_mem [fam_pkg::ARRAY_BYTES]; // [R1] [R2]
    logic [7:0] sreg_mem [3 * fam_pkg::SREG_BYTES]; // [R6]

    fam_state_e state_q, state_d;
    logic [AW-1:0] ptr_q, ptr_d, last_q, last_d;
    logic tgt_sreg_q, tgt_sreg_d;
    logic ready_q, ready_d;
    logic rsp_valid_q, rsp_valid_d;
    fam_pkg::fam_rsp_s rsp_q, rsp_d;
    logic [3:1] lock_q, lock_d;

    logic take;
    logic main_ok, sreg_ok;
    logic [1:0] sel;
    logic [SW-1:0] sidx;
    logic [7:0] rom_data;
    logic mwe, swe;
    logic [AW-1:0] mwaddr;
    logic [SW-1:0] swaddr;
    logic [7:0] mwdata, swdata;

    assign take = req_valid && ready_q;
    assign main_ok = (req.addr[fam_pkg::ADDR_W-1:AW] == '0); // [R1]
    assign sel = req.addr[fam_pkg::SREG_SEL_LSB +: 2];
    // Register space: only 000000h-0030FFh style slots are decoded
    assign sreg_ok = (req.addr[fam_pkg::ADDR_W-1:14] == '0) &&
                     (req.addr[11:8] == 4'h0); // [R6]
    assign sidx = {sel - 2'h1, req.addr[7:0]};

    fam_param_rom #(
        .MAJOR_REV(8'h01),
        .BASIC_TABLE(BASIC_TABLE)
    ) u_rom (
        .addr(req.addr[7:0]),
        .data(rom_data)
    );

    always_comb begin
        state_d = state_q;
        ptr_d = ptr_q;
        last_d = last_q;
        tgt_sreg_d = tgt_sreg_q;
        rsp_valid_d = 1'b0;
        rsp_d = rsp_q;
        lock_d = lock_q;
        mwe = 1'b0;
        mwaddr = req.addr[AW-1:0];
        mwdata = main_mem[req.addr[AW-1:0]] & req.data; // [R3]
        swe = 1'b0;
        swaddr = sidx;
        swdata = sreg_mem[sidx] & req.data; // [R3]
        unique case (state_q)
            FAM_IDLE: begin
                if (take) begin
                    rsp_valid_d = 1'b1;
                    rsp_d.err = 1'b1;
                    rsp_d.data = fam_pkg::ERASED_BYTE;
                    unique case (req.opcode)
                        fam_pkg::OP_READ: begin
                            if (main_ok) begin
                                rsp_d.err = 1'b0;
                                rsp_d.data = main_mem[req.addr[AW-1:0]];
                            end
                        end
                        fam_pkg::OP_PROG: begin
                            if (main_ok) begin // [R2]
                                rsp_d.err = 1'b0;
                                mwe = 1'b1;
                            end
                        end
                        fam_pkg::OP_SEC_ERASE: begin
                            if (main_ok) begin // [R4] [R5]
                                rsp_valid_d = 1'b0;
                                state_d = FAM_ERASE;
                                tgt_sreg_d = 1'b0;
                                ptr_d = {req.addr[AW-1:fam_pkg::SECTOR_AW],
                                         {fam_pkg::SECTOR_AW{1'b0}}};
                                last_d = {req.addr[AW-1:fam_pkg::SECTOR_AW],
                                          {fam_pkg::SECTOR_AW{1'b1}}};
                            end
                        end
                        fam_pkg::OP_BLK_ERASE: begin
                            if (main_ok) begin // [R4] [R1]
                                rsp_valid_d = 1'b0;
                                state_d = FAM_ERASE;
                                tgt_sreg_d = 1'b0;
                                ptr_d = {req.addr[AW-1:fam_pkg::BLOCK_AW],
                                         {fam_pkg::BLOCK_AW{1'b0}}};
                                last_d = {req.addr[AW-1:fam_pkg::BLOCK_AW],
                                          {fam_pkg::BLOCK_AW{1'b1}}};
                            end
                        end
                        fam_pkg::OP_CHIP_ERASE: begin // [R4]
                            rsp_valid_d = 1'b0;
                            state_d = FAM_ERASE;
                            tgt_sreg_d = 1'b0;
                            ptr_d = '0;
                            last_d = '1;
                        end
                        fam_pkg::OP_SREG_READ: begin
                            if (sreg_ok) begin
                                rsp_d.err = 1'b0;
                                rsp_d.data = (sel == 2'h0) ? rom_data
                                                           : sreg_mem[sidx];
                            end
                        end
                        fam_pkg::OP_SREG_PROG: begin
                            // Register 0 holds factory content
                            if (sreg_ok && sel != 2'h0 &&
                                !lock_q[sel]) begin // [R9] [R10] [R7]
                                rsp_d.err = 1'b0;
                                swe = 1'b1;
                            end
                        end
                        fam_pkg::OP_SREG_ERASE: begin
                            if (sreg_ok && sel != 2'h0 &&
                                !lock_q[sel]) begin // [R9] [R10] [R7]
                                rsp_valid_d = 1'b0;
                                state_d = FAM_ERASE;
                                tgt_sreg_d = 1'b1;
                                ptr_d = AW'({sidx[SW-1:8], 8'h00});
                                last_d = AW'({sidx[SW-1:8], 8'hFF});
                            end
                        end
                        fam_pkg::OP_SREG_LOCK: begin
                            if (sreg_ok && sel != 2'h0) begin // [R9]
                                rsp_d.err = 1'b0;
                                lock_d[sel] = 1'b1; // [R7]
                            end
                        end
                        fam_pkg::OP_READ_PARAM: begin // [R8]
                            rsp_d.err = 1'b0;
                            if (req.addr[fam_pkg::ADDR_W-1:8] == '0) begin
                                rsp_d.data = rom_data; // [R11] [R13]
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            FAM_ERASE: begin
                mwaddr = ptr_q;
                mwdata = fam_pkg::ERASED_BYTE;
                swaddr = ptr_q[SW-1:0];
                swdata = fam_pkg::ERASED_BYTE;
                mwe = !tgt_sreg_q;
                swe = tgt_sreg_q;
                ptr_d = ptr_q + AW'(1);
                if (ptr_q == last_q) begin
                    state_d = FAM_IDLE;
                    rsp_valid_d = 1'b1;
                    rsp_d.err = 1'b0;
                    rsp_d.data = fam_pkg::ERASED_BYTE;
                end
            end
        endcase
        // One idle cycle after every answer keeps answers one apart
        ready_d = (state_d == FAM_IDLE) && !rsp_valid_d;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= FAM_IDLE;
            ptr_q <= '0;
            last_q <= '0;
            tgt_sreg_q <= 1'b0;
            ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
            lock_q <= '0;
        end else begin
            state_q <= state_d;
            ptr_q <= ptr_d;
            last_q <= last_d;
            tgt_sreg_q <= tgt_sreg_d;
            ready_q <= ready_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_q <= rsp_d;
            lock_q <= lock_d;
        end
    end

    // Storage has no reset: contents survive like the real cells
    always_ff @(posedge ref_clk) begin
        if (mwe) begin
            main_mem[mwaddr] <= mwdata;
        end
        if (swe) begin
            sreg_mem[swaddr] <= swdata;
        end
    end

    assign req_ready = ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp = rsp_q;
    assign busy = (state_q == FAM_ERASE);
    assign sreg_lock = {lock_q, 1'b1};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_prog_no_set: assert property ( // [R3]
        (state_q == FAM_IDLE && mwe) |->
            ((mwdata & ~main_mem[mwaddr]) == 8'h00))
        else $error("program set a bit in the main array");

    chk_erase_start_align: assert property ( // [R5]
        $rose(busy) && !tgt_sreg_q |->
            ptr_q[fam_pkg::SECTOR_AW-1:0] == '0 &&
            last_q[fam_pkg::SECTOR_AW-1:0] == '1)
        else $error("erase range not sector aligned");

    chk_lock_sticky: assert property ( // [R7]
        ($past(lock_q) & ~lock_q) == 3'b000)
        else $error("security lock bit cleared");

    chk_locked_reject: assert property ( // [R9]
        take && req.opcode == fam_pkg::OP_SREG_PROG && sreg_ok &&
        sel != 2'h0 && lock_q[sel] |-> !swe ##1 (rsp_valid && rsp.err))
        else $error("locked register accepted a program");

    chk_param_readonly: assert property ( // [R10]
        take && (req.opcode == fam_pkg::OP_SREG_PROG ||
                 req.opcode == fam_pkg::OP_SREG_ERASE) && sel == 2'h0
        |-> !swe ##1 (rsp_valid && rsp.err && !busy))
        else $error("parameter space was written");

    chk_sig_first: assert property ( // [R15]
        take && req.opcode == fam_pkg::OP_READ_PARAM &&
        req.addr == '0 |=> rsp_valid && rsp.data == 8'h53)
        else $error("signature byte 0 wrong");

    chk_reserved_ff: assert property ( // [R13]
        take && req.opcode == fam_pkg::OP_READ_PARAM &&
        req.addr[fam_pkg::ADDR_W-1:8] == '0 && req.addr[7:0] > 8'h6F
        |=> rsp.data == 8'hFF)
        else $error("reserved parameter byte not erased value");

    chk_hdr_ext_ff: assert property ( // [R16]
        take && req.opcode == fam_pkg::OP_READ_PARAM &&
        req.addr >= 24'h000010 && req.addr < 24'h000030
        |=> rsp.data == 8'hFF && !rsp.err)
        else $error("header extension byte not erased value");

    chk_tbl_pointer: assert property ( // [R12]
        take && req.opcode == fam_pkg::OP_READ_PARAM &&
        req.addr == 24'h00000C |=> rsp.data == 8'h30)
        else $error("table pointer wrong");

    chk_read_answer: assert property ( // [R8]
        take && req.opcode == fam_pkg::OP_READ
        |=> rsp_valid && !req_ready ##1 !rsp_valid && req_ready)
        else $error("read answer timing wrong");

    chk_sector_erase_len: assert property ( // [R4]
        take && req.opcode == fam_pkg::OP_SEC_ERASE && main_ok
        |=> busy [*8])
        else $error("sector erase ended early");

    cov_param_read: cover property (
        take && req.opcode == fam_pkg::OP_READ_PARAM);
    cov_erase_done: cover property ($fell(busy) && rsp_valid);
    cov_lock: cover property ($rose(lock_q[1]));
    cov_prog: cover property (mwe && state_q == FAM_IDLE);
endmodule // fam_flash_core
`default_nettype wire

/* File: pkg/fam_pkg.sv */
// Constants, opcodes and carrier structs for the flash array map core.
// Assumes a front end on the same clock that turns serial frames into
// one request word per command and takes back one answer per command.
// Behaviour
// R1: 2 MB: 32 64-KB blocks, 512 sectors.
// R2: 8192 pages of 256 bytes, each programmable.
// R3: Programming only moves bits from 1 to 0.
// R4: Sector, block and chip erase; no page erase.
// R5: Sectors span XXX000h to XXXFFFh.
// R6: Four 256-byte security registers, separate space.
// R7: One-time lock per register, never cleared. (Here rst clears lock_q.)
// R8: Opcode 5Ah reads the parameter space.
// R9: Registers 1-3 erase, program, lock independently.
// R10: Parameter space is read-only to the host.
// R11: Header at 0000h, extension space from 0010h.
// R12: Basic parameter table starts at 0030h.
// R13: Space ends 006Fh; 0070h-00FFh reserved.
// R14: Header first, then the single basic table.
// R15: Bytes 00h-03h hold 53h 46h 44h 50h.
// R16: Reserved or undefined locations read as FFh.
// R17: Host bounds-checks addresses before program or erase.
`default_nettype none
package fam_pkg;
    localparam int ADDR_W = 24;
    localparam int ARRAY_BYTES = 2097152;
    localparam int BLOCK_BYTES = 65536;
    localparam int SECTOR_BYTES = 4096;
    localparam int PAGE_BYTES = 256;
    localparam int N_BLOCKS = 32;
    localparam int N_SECTORS = 512;
    localparam int N_PAGES = 8192;
    localparam int ARRAY_AW = $clog2(ARRAY_BYTES);
    localparam int SECTOR_AW = $clog2(SECTOR_BYTES);
    localparam int BLOCK_AW = $clog2(BLOCK_BYTES);
    localparam int SREG_BYTES = 256;
    localparam int N_SREG = 4;
    localparam int SREG_SEL_LSB = 12;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // Parameter space map, byte addresses inside security register 0
    localparam logic [7:0] PAR_HDR_ADDR = 8'h00;
    localparam logic [7:0] PAR_HDR_EXT_ADDR = 8'h10;
    localparam logic [7:0] PAR_TBL_ADDR = 8'h30;
    localparam logic [7:0] PAR_END_ADDR = 8'h6F;
    localparam logic [7:0] PAR_SIG0 = 8'h53;
    localparam logic [7:0] PAR_SIG1 = 8'h46;
    localparam logic [7:0] PAR_SIG2 = 8'h44;
    localparam logic [7:0] PAR_SIG3 = 8'h50;
    localparam logic [7:0] PAR_MINOR_REV = 8'h06;
    localparam logic [7:0] PAR_TBL_DWORDS = 8'h10;

    // Command opcodes
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_SEC_ERASE = 8'h20;
    localparam logic [7:0] OP_BLK_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
    localparam logic [7:0] OP_SREG_READ = 8'h48;
    localparam logic [7:0] OP_SREG_PROG = 8'h42;
    localparam logic [7:0] OP_SREG_ERASE = 8'h44;
    localparam logic [7:0] OP_SREG_LOCK = 8'h4F;
    localparam logic [7:0] OP_READ_PARAM = 8'h5A;

    typedef struct packed {
        logic [7:0] opcode;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } fam_req_s;

    typedef struct packed {
        logic err;
        logic [7:0] data;
    } fam_rsp_s;
endpackage
`default_nettype wire

/* File: rtl/fam_param_rom.sv */
// Factory content of the parameter space (security register 0).
// Pure lookup; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module fam_param_rom #(
    parameter logic [7:0] MAJOR_REV = 8'h01,
    parameter logic [511:0] BASIC_TABLE = {512{1'b1}}
) (
    // Lookup
    input wire logic [7:0] addr,
    output logic [7:0] data
);
    always_comb begin
        data = fam_pkg::ERASED_BYTE; // [R16]
        if (addr < fam_pkg::PAR_HDR_EXT_ADDR) begin // [R11] [R14]
            unique case (addr[3:0])
                4'h0: data = fam_pkg::PAR_SIG0; // [R15]
                4'h1: data = fam_pkg::PAR_SIG1;
                4'h2: data = fam_pkg::PAR_SIG2;
                4'h3: data = fam_pkg::PAR_SIG3;
                4'h4: data = fam_pkg::PAR_MINOR_REV;
                4'h5: data = MAJOR_REV;
                4'h6: data = 8'h00;
                4'h8: data = 8'h00;
                4'h9: data = fam_pkg::PAR_MINOR_REV;
                4'hA: data = MAJOR_REV;
                4'hB: data = fam_pkg::PAR_TBL_DWORDS;
                4'hC: data = fam_pkg::PAR_TBL_ADDR; // [R12]
                4'hD: data = 8'h00;
                4'hE: data = 8'h00;
                default: data = fam_pkg::ERASED_BYTE;
            endcase
        end else if (addr >= fam_pkg::PAR_TBL_ADDR &&
                     addr <= fam_pkg::PAR_END_ADDR) begin // [R12] [R13]
            data = BASIC_TABLE[8*(addr - fam_pkg::PAR_TBL_ADDR) +: 8];
        end
    end
endmodule // fam_param_rom
`default_nettype wire

/* File: tb/fam_host_model.sv */
// Host controller model: drives one request at a time into the core.
// Assumes the core's valid/ready take and single-pulse answer on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module fam_host_model (
    // Clock
    input wire logic ref_clk,
    // Requests
    output logic req_valid,
    output fam_pkg::fam_req_s req,
    input wire logic req_ready,
    // Answers
    input wire logic rsp_valid,
    input wire fam_pkg::fam_rsp_s rsp,
    input wire logic busy
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    task automatic issue(input fam_pkg::fam_req_s r,
                         output fam_pkg::fam_rsp_s a, output int lat,
                         output int nb, output bit ok, input int lim);
        int n;
        n = 0;
        lat = 0;
        nb = 0;
        ok = 1'b0;
        a = '0;
        @(posedge ref_clk);
        #2;
        req = r;
        req_valid = 1'b1;
        // Ready moves on rising edges only, so the low phase shows the take
        do begin
            @(negedge ref_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 100);
        @(posedge ref_clk);
        #2;
        req_valid = 1'b0;
        // Released fields are inverted so a stale copy cannot pass
        req = ~r;
        // A short limit cuts an answer that the caller will not wait for
        while (lat < lim) begin
            @(negedge ref_clk);
            lat++;
            if (busy === 1'b1) nb++;
            if (rsp_valid === 1'b1) begin
                a = rsp;
                ok = 1'b1;
                break;
            end
        end
    endtask
endmodule // fam_host_model
`default_nettype wire

/* File: tb/flash_array_map_and_param_space_bench.sv */
// Self-checking bench for the flash array map core.
// Assumes fam_host_model issues requests; memory model kept here.
`timescale 1ns/1ns
`default_nettype none
module flash_array_map_and_param_space_bench;
    localparam logic [511:0] BT = {16{32'hC3B2A190}};
    localparam logic [127:0] HDR = 128'hFF000030_10010600_FF000106_50444653;
    logic ref_clk;
    logic rst;
    logic req_valid;
    logic req_ready;
    logic rsp_valid;
    logic busy;
    logic [3:0] sreg_lock;
    fam_pkg::fam_req_s req;
    fam_pkg::fam_rsp_s rsp;
    int fail_count = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'h30;
    logic [7:0] mem [int];
    logic [7:0] sreg_m [int];
    logic [3:0] lock_m = 4'h0;
    int bnd [8] = '{'h0FFFF, 'h10000, 'h1FFFF, 'h20000,
                    'h11FFF, 'h12000, 'h12FFF, 'h13000};

    fam_flash_core #(.BASIC_TABLE(BT)) uut (.ref_clk(ref_clk), .rst(rst),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp(rsp), .busy(busy),
        .sreg_lock(sreg_lock));
    fam_host_model host (.ref_clk(ref_clk), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp(rsp), .busy(busy));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] par(int a);
        if (a < 16) return HDR[a*8 +: 8];
        if (a >= 48 && a < 112) return BT[(a-48)*8 +: 8];
        return 8'hFF;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic op(input logic [7:0] o, input int a, input logic [7:0] d);
        fam_pkg::fam_req_s r;
        fam_pkg::fam_rsp_s s;
        int lat, nb, n, base, g, k;
        bit ok, err, dv, sv;
        logic [7:0] ed;
        r = '{opcode: o, addr: a[23:0], data: d};
        n = 0;
        err = 0;
        dv = 0;
        ed = 8'hFF;
        g = a[13:12];
        k = g * 256 + a[7:0];
        sv = (a[23:14] == 0 && a[11:8] == 0);
        case (o)
            fam_pkg::OP_READ: begin
                err = a >= fam_pkg::ARRAY_BYTES;
                dv = !err;
                if (dv) ed = mem[a];
            end
            fam_pkg::OP_PROG: begin
                err = a >= fam_pkg::ARRAY_BYTES;
                if (!err) mem[a] = (mem.exists(a) ? mem[a] : 'x) & d;
            end
            fam_pkg::OP_SEC_ERASE, fam_pkg::OP_BLK_ERASE: begin
                err = a >= fam_pkg::ARRAY_BYTES;
                dv = !err;
                n = (o == fam_pkg::OP_SEC_ERASE) ? 4096 : 65536;
                base = a & ~(n - 1);
                if (!err) for (int i = 0; i < n; i++) mem[base+i] = 8'hFF;
            end
            fam_pkg::OP_SREG_READ: begin
                err = !sv;
                dv = sv;
                if (sv) ed = (g == 0) ? par(a[7:0]) : sreg_m[k];
            end
            fam_pkg::OP_SREG_PROG: begin
                err = !sv || g == 0 || lock_m[g];
                if (!err) sreg_m[k] = sreg_m[k] & d;
            end
            fam_pkg::OP_SREG_ERASE: begin
                err = !sv || g == 0 || lock_m[g];
                dv = !err;
                n = 256;
                if (!err) for (int i = 0; i < n; i++) sreg_m[g*256+i] = 8'hFF;
            end
            fam_pkg::OP_SREG_LOCK: begin
                err = !sv || g == 0;
                if (!err) lock_m[g] = 1'b1;
            end
            fam_pkg::OP_READ_PARAM: begin
                dv = 1;
                ed = (a < 256) ? par(a) : 8'hFF;
            end
            default: err = 1;
        endcase
        host.issue(r, s, lat, nb, ok, 70000);
        check(ok, 1);
        check(s.err, err);
        if (dv) check(s.data, ed);
        if (!err) check(lat, n + 1);
        if (!err) check(nb, n);
        check(sreg_lock, {lock_m[3:1], 1'b1});
    endtask

    initial begin
        #(100000 * 50);
        fail_count++;
        complete_run();
    end

    initial begin
        int a;
        int lat;
        int nb;
        bit ok;
        fam_pkg::fam_req_s r;
        fam_pkg::fam_rsp_s s;
        rst = 1'b1;
        repeat (10) @(posedge ref_clk);
        #2;
        rst = 1'b0;
        check(sreg_lock, 4'h1);
        for (int i = 0; i < 272; i++) op(fam_pkg::OP_READ_PARAM, i, 0);
        op(fam_pkg::OP_SREG_READ, 0, 0);
        op(fam_pkg::OP_SREG_READ, 5, 0);
        op(fam_pkg::OP_SREG_PROG, 0, 0);
        op(fam_pkg::OP_SREG_ERASE, 0, 0);
        op(fam_pkg::OP_SREG_LOCK, 0, 0);
        op(fam_pkg::OP_READ_PARAM, 0, 0);
        for (int i = 0; i < 4; i++) op(fam_pkg::OP_PROG, bnd[i], 0);
        op(fam_pkg::OP_BLK_ERASE, 'h15555, 0);
        for (int i = 0; i < 4; i++) op(fam_pkg::OP_READ, bnd[i], 0);
        for (int i = 4; i < 8; i++) op(fam_pkg::OP_PROG, bnd[i], 0);
        op(fam_pkg::OP_SEC_ERASE, 'h12ABC, 0);
        for (int i = 0; i < 8; i++) op(fam_pkg::OP_READ, bnd[i], 0);
        for (int i = 0; i < 8; i++) begin
            a = 'h10000 + (rnd() & 'hFFFF);
            op(fam_pkg::OP_PROG, a, 8'(rnd()));
            op(fam_pkg::OP_PROG, a, 8'(rnd()));
            op(fam_pkg::OP_READ, a, 0);
        end
        op(fam_pkg::OP_READ, 'h200000, 0);
        op(fam_pkg::OP_PROG, 'h200000, 0);
        op(fam_pkg::OP_SEC_ERASE, 'h200000, 0);
        op(8'h9F, 0, 0);
        // Chip erase outlasts the run; a mid-run reset cuts it short
        r = '{opcode: fam_pkg::OP_CHIP_ERASE, addr: 24'h000000, data: 8'h00};
        host.issue(r, s, lat, nb, ok, 20);
        check(ok, 0);
        check(nb, 20);
        @(posedge ref_clk);
        #2;
        rst = 1'b1;
        // Two edges so the lock history before release is the reset value
        repeat (2) @(posedge ref_clk);
        #2;
        check(busy, 0);
        check(req_ready, 0);
        check(rsp_valid, 0);
        check(sreg_lock, 4'h1);
        rst = 1'b0;
        for (int g = 1; g < 4; g++) begin
            op(fam_pkg::OP_SREG_ERASE, g * 'h1000, 0);
        end
        for (int i = 0; i < 4; i++) begin
            a = rnd() & 'hFF;
            for (int g = 1; g < 4; g++) begin
                op(fam_pkg::OP_SREG_PROG, g * 'h1000 + a, 8'(rnd()));
                op(fam_pkg::OP_SREG_READ, g * 'h1000 + a, 0);
            end
        end
        op(fam_pkg::OP_SREG_LOCK, 'h1000, 0);
        op(fam_pkg::OP_SREG_PROG, 'h1000, 0);
        op(fam_pkg::OP_SREG_ERASE, 'h1000, 0);
        op(fam_pkg::OP_SREG_READ, 'h1000, 0);
        op(fam_pkg::OP_SREG_PROG, 'h2000, 0);
        op(fam_pkg::OP_SREG_READ, 'h2000, 0);
        op(fam_pkg::OP_SREG_LOCK, 'h3000, 0);
        op(fam_pkg::OP_SREG_READ, 'h1100, 0);
        op(fam_pkg::OP_SREG_READ, 'h4000, 0);
        complete_run();
    end
endmodule // flash_array_map_and_param_space_bench
`default_nettype wire
